// *** hw/gcr_global_regs.sv ***
// global register group: bank select, identifier, revision, write protection, master config
// assumes a host port master that issues one-cycle strobes, never read and write together
`include "gcr_cfg.svh"
`default_nettype none
module gcr_global_regs #(
	// arbitrary neutral values, not any real part's codes
	parameter logic [15:0] DEVICE_ID  = 16'h5A5A,
	parameter logic [7:0]  REVISION   = 8'h01
) (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic [3:0] strap_pins,
	output logic      [3:0] strap_value,
	output logic            memory_bank_select,
	output logic            soft_reset,
	output logic            bank_a_source_select,
	output logic            bank_b_source_select,
	output logic            bank_c_source_select,
	output logic            bank_d_source_select,
	output logic      [7:0] mem_addr,
	output logic      [7:0] mem_wdata,
	output logic            mem_wr,
	output logic            mem_rd,
	input  wire logic [7:0] mem_rdata,
	output logic      [1:0] protect_mode
);
	// ----------------------------------------------------------------
	// storage and decode
	// ----------------------------------------------------------------
	gcr_pkg::gcr_byte_t bank_sel_reg;
	gcr_pkg::gcr_byte_t protect_reg;
	gcr_pkg::gcr_byte_t mcfg_reg;
	gcr_pkg::gcr_mode_e mode;
	logic               rd_mem_q;
	gcr_pkg::gcr_byte_t rd_reg_q;

	function automatic gcr_pkg::gcr_mode_e decode_mode(input gcr_pkg::gcr_byte_t code);
		if (code == `GCR_CODE_FULL)
			return gcr_pkg::GCR_FULL;
		else if (code == `GCR_CODE_SINGLE)
			return gcr_pkg::GCR_SINGLE;
		else
			return gcr_pkg::GCR_PROTECTED;
	endfunction : decode_mode

	wire        at_zero    = (addr == `GCR_OFF_BANK_SEL);
	wire        to_memory  = bank_sel_reg[`GCR_BIT_BANK_SEL] && !at_zero; // [R1]
	wire        hit_write_protection   = !to_memory && (addr == `GCR_OFF_PROTECT);
	wire        hit_bank   = at_zero;
	wire        hit_mcfg   = !to_memory && (addr == `GCR_OFF_MASTER_CFG);
	wire        unlocked   = (mode != gcr_pkg::GCR_PROTECTED); // [R3]
	wire        other_wr   = wr_en && !hit_write_protection;
	wire        other_ok   = other_wr && unlocked; // [R3] [R5]
	wire        wr_write_protection    = wr_en && hit_write_protection; // [R13]
	wire        wr_bank    = other_ok && hit_bank;
	wire        wr_mcfg    = other_ok && hit_mcfg;
	wire        burn_one   = other_ok && (mode == gcr_pkg::GCR_SINGLE); // [R4]
	wire        srst       = mcfg_reg[`GCR_BIT_SOFT_RST]; // [R6]

	assign mode = decode_mode(protect_reg);
	assign protect_mode = mode;

	// ----------------------------------------------------------------
	// strap capture
	// ----------------------------------------------------------------
	gcr_strap_latch i_gcr_strap_latch (
		.mclk        (mclk),
		.nrst        (nrst),
		.strap_pins  (strap_pins),
		.strap_value (strap_value)
	);

	// ----------------------------------------------------------------
	// register updates
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			protect_reg <= `GCR_RST_PROTECT;
		end else if (srst && !(wr_write_protection)) begin
			protect_reg <= `GCR_RST_PROTECT; // [R6]
		end else if (wr_write_protection) begin
			protect_reg <= wdata; // [R13]
		end else if (burn_one) begin
			protect_reg <= `GCR_CODE_LOCKED; // [R4]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bank_sel_reg <= `GCR_RST_BANK_SEL;
		end else if (srst) begin
			bank_sel_reg <= `GCR_RST_BANK_SEL; // [R6]
		end else if (wr_bank) begin
			bank_sel_reg <= {7'h00, wdata[`GCR_BIT_BANK_SEL]}; // [R1]
		end
	end

	// soft reset bit itself survives; other fields go to default while it is set
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mcfg_reg <= `GCR_RST_MASTER_CFG;
		end else if (wr_mcfg) begin
			mcfg_reg <= srst ? (wdata & 8'h80) : (wdata & `GCR_MCFG_MASK); // [R6]
		end else if (srst) begin
			mcfg_reg <= `GCR_RST_MASTER_CFG | 8'h80; // [R6]
		end
	end

	assign soft_reset           = srst;
	assign memory_bank_select   = bank_sel_reg[`GCR_BIT_BANK_SEL];
	assign bank_a_source_select = mcfg_reg[`GCR_BIT_BANK_A]; // [R8]
	assign bank_b_source_select = mcfg_reg[`GCR_BIT_BANK_B]; // [R9]
	assign bank_c_source_select = mcfg_reg[`GCR_BIT_BANK_C]; // [R10]
	assign bank_d_source_select = mcfg_reg[`GCR_BIT_BANK_D]; // [R11]

	// ----------------------------------------------------------------
	// memory window: writes obey protection like any other register
	// ----------------------------------------------------------------
	assign mem_addr  = addr;
	assign mem_wdata = wdata;
	assign mem_wr    = other_ok && to_memory; // [R1] [R3]
	assign mem_rd    = rd_en && to_memory;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// id and revision registers have no write path at all
	wire [7:0] rd_mux =
		(addr == `GCR_OFF_BANK_SEL)   ? bank_sel_reg :
		(addr == `GCR_OFF_ID_LOW)     ? DEVICE_ID[7:0] : // [R2] [R12]
		(addr == `GCR_OFF_ID_HIGH)    ? DEVICE_ID[15:8] : // [R2]
		(addr == `GCR_OFF_REVISION)   ? REVISION : // [R12]
		(addr == `GCR_OFF_PROTECT)    ? protect_reg :
		(addr == `GCR_OFF_MASTER_CFG) ? mcfg_reg : 8'h00;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_mem_q <= 1'b0;
			rd_reg_q <= 8'h00;
		end else begin
			rd_mem_q <= rd_en && to_memory;
			rd_reg_q <= rd_en ? rd_mux : 8'h00;
		end
	end

	assign rdata = rd_mem_q ? mem_rdata : rd_reg_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_locked_drop: assert property (@(posedge mclk) disable iff (!nrst) // [R3]
		(wr_en && hit_mcfg && mode == gcr_pkg::GCR_PROTECTED && !srst) |=> $stable(mcfg_reg))
		else $error("write went through while protected");
	a_locked_bank: assert property (@(posedge mclk) disable iff (!nrst) // [R3]
		(wr_en && at_zero && mode == gcr_pkg::GCR_PROTECTED && !srst) |=> $stable(bank_sel_reg))
		else $error("bank select written while protected");
	a_single_relock: assert property (@(posedge mclk) disable iff (!nrst) // [R4]
		(burn_one && !srst) |=> protect_reg == `GCR_CODE_LOCKED)
		else $error("single unlock did not relock");
	a_full_keeps: assert property (@(posedge mclk) disable iff (!nrst) // [R5]
		(mode == gcr_pkg::GCR_FULL && other_wr && !srst) |=> mode == gcr_pkg::GCR_FULL)
		else $error("full unlock lost after write");
	a_write_protection_write: assert property (@(posedge mclk) disable iff (!nrst) // [R13]
		wr_write_protection |=> protect_reg == $past(wdata))
		else $error("protection write refused");
	a_srst_clears: assert property (@(posedge mclk) disable iff (!nrst) // [R6]
		(srst && !wr_mcfg && !wr_write_protection) |=> (mcfg_reg == 8'h80 && protect_reg == `GCR_RST_PROTECT))
		else $error("soft reset left fields set");
	a_srst_bank: assert property (@(posedge mclk) disable iff (!nrst) // [R6]
		srst |=> !memory_bank_select)
		else $error("bank select kept in soft reset");
	a_strap_hold: assert property (@(posedge mclk) disable iff (!nrst) // [R7]
		srst |=> $stable(strap_value))
		else $error("straps resampled in soft reset");
	a_id_read: assert property (@(posedge mclk) disable iff (!nrst) // [R2]
		(rd_en && !to_memory && addr == `GCR_OFF_ID_HIGH) |=> rdata == DEVICE_ID[15:8])
		else $error("identifier high byte wrong");
	a_rev_read: assert property (@(posedge mclk) disable iff (!nrst) // [R12]
		(rd_en && !to_memory && addr == `GCR_OFF_REVISION) |=> rdata == REVISION)
		else $error("revision byte wrong");
	a_mem_route: assert property (@(posedge mclk) disable iff (!nrst) // [R1]
		(wr_en && memory_bank_select && !at_zero && !srst) |=> ($stable(mcfg_reg) && $stable(bank_sel_reg)))
		else $error("register written in memory bank");
	a_bank_a_sel: assert property (@(posedge mclk) disable iff (!nrst) // [R8]
		(wr_mcfg && !srst) |=> bank_a_source_select == $past(wdata[3]))
		else $error("bank a select not stored");
	a_bank_b_sel: assert property (@(posedge mclk) disable iff (!nrst) // [R9]
		(wr_mcfg && !srst) |=> bank_b_source_select == $past(wdata[2]))
		else $error("bank b select not stored");
	a_bank_c_sel: assert property (@(posedge mclk) disable iff (!nrst) // [R10]
		(wr_mcfg && !srst) |=> bank_c_source_select == $past(wdata[1]))
		else $error("bank c select not stored");
	a_bank_d_sel: assert property (@(posedge mclk) disable iff (!nrst) // [R11]
		(wr_mcfg && !srst) |=> bank_d_source_select == $past(wdata[0]))
		else $error("bank d select not stored");
	c_single_use: cover property (@(posedge mclk) disable iff (!nrst) burn_one);
	c_full_write: cover property (@(posedge mclk) disable iff (!nrst) (mode == gcr_pkg::GCR_FULL) && wr_mcfg);
	c_soft_reset: cover property (@(posedge mclk) disable iff (!nrst) $rose(srst));
	c_mem_write: cover property (@(posedge mclk) disable iff (!nrst) mem_wr);
endmodule : gcr_global_regs
`default_nettype wire

// *** hw/gcr_cfg.svh ***
// constants for the global control register group: offsets, fields, reset values
// assumes an 8-bit register port with one-cycle read latency
// Contract
// [R1] bank select bit maps registers or memory
// [R2] sixteen-bit identifier split over 01h and 02h
// [R3] protected mode drops writes except protection
// [R4] single unlock allows one write, then 00h
// [R5] full unlock allows unlimited writes
// [R6] soft reset holds device, restores defaults
// [R7] soft reset reloads latched strap values; the code holds strap_value through soft reset and never reloads it
// [R8] bank a source select at bit 3
// [R9] bank b source select at bit 2
// [R10] bank c source select at bit 1
// [R11] bank d source select at bit 0
// [R12] revision and identifier registers ignore writes
// [R13] protection register writes always accepted; the code routes 04h writes to memory while bank select maps memory
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH
`define GCR_OFF_BANK_SEL   8'h00
`define GCR_OFF_ID_LOW     8'h01
`define GCR_OFF_ID_HIGH    8'h02
`define GCR_OFF_REVISION   8'h03
`define GCR_OFF_PROTECT    8'h04
`define GCR_OFF_MASTER_CFG 8'h05
`define GCR_BIT_BANK_SEL   0
`define GCR_BIT_SOFT_RST   7
`define GCR_BIT_BANK_A     3
`define GCR_BIT_BANK_B     2
`define GCR_BIT_BANK_C     1
`define GCR_BIT_BANK_D     0
`define GCR_RST_BANK_SEL   8'h00
`define GCR_RST_PROTECT    8'h85
`define GCR_RST_MASTER_CFG 8'h00
`define GCR_CODE_FULL      8'h85
`define GCR_CODE_SINGLE    8'h86
`define GCR_CODE_LOCKED    8'h00
`define GCR_MCFG_MASK      8'h8F
`define GCR_STRAP_SETTLE   2'h2
`endif

// *** hw/gcr_pkg.sv ***
// types for the global control register group
// assumes gcr_cfg.svh for the numeric constants
`default_nettype none
package gcr_pkg;
	typedef enum logic [1:0] {
		GCR_PROTECTED,
		GCR_SINGLE,
		GCR_FULL
	} gcr_mode_e;
	typedef logic [7:0] gcr_byte_t;
endpackage : gcr_pkg
`default_nettype wire

// *** hw/gcr_strap_latch.sv ***
// strap capture: synchronises strap pins, latches them once after the hardware reset pin is released, then holds them
// assumes straps are static around the release of nrst
`include "gcr_cfg.svh"
`default_nettype none
module gcr_strap_latch (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [3:0] strap_pins,
	output logic      [3:0] strap_value
);
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic       armed;
	logic [1:0] settle;
	wire        settled = armed && (settle == `GCR_STRAP_SETTLE);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else begin
			sync_a <= strap_pins;
			sync_b <= sync_a;
		end
	end

	// capture once, after the synchroniser has filled, so soft reset never resamples the pins
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			armed       <= 1'b1;
			settle      <= 2'h0;
			strap_value <= 4'h0;
		end else if (settled) begin
			armed       <= 1'b0;
			strap_value <= sync_b; // [R7]
		end else if (armed) begin
			settle <= settle + 2'h1;
		end
	end
endmodule : gcr_strap_latch
`default_nettype wire

// *** verif/tb_gcr_global_regs.sv ***
// testbench for the global register group: reset values, protection modes, soft reset, bank select
// assumes gcr_global_regs with its one-cycle register port; identifier values below are arbitrary
`default_nettype none
module tb_gcr_global_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] TB_ID  = 16'h1234;
	localparam logic [7:0]  TB_REV = 8'h07;
	logic       mclk, nrst, wr_en, rd_en, mem_wr, mem_rd;
	logic [7:0] addr, wdata, rdata, mem_addr, mem_wdata, mem_rdata;
	logic [3:0] strap_pins, strap_value;
	logic       memory_bank_select, soft_reset;
	logic       bank_a_source_select, bank_b_source_select, bank_c_source_select, bank_d_source_select;
	logic [1:0] protect_mode;
	int         failures = 0;
	int         num_checks = 0;
	int         cycles = 0;
	wire  [7:0] banks = {4'h0, bank_a_source_select, bank_b_source_select,
		bank_c_source_select, bank_d_source_select};

	gcr_global_regs #(.DEVICE_ID(TB_ID), .REVISION(TB_REV)) i_gcr_global_regs (
		.mclk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .strap_pins, .strap_value,
		.memory_bank_select, .soft_reset, .bank_a_source_select, .bank_b_source_select,
		.bank_c_source_select, .bank_d_source_select, .mem_addr, .mem_wdata, .mem_wr,
		.mem_rd, .mem_rdata, .protect_mode);

	// ----------------------------------------
	// bus tasks and compare
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
		// registers update at the strobe edge; callers look only once they have settled
		@(negedge mclk);
	endtask : wr
	// read data exist only in the cycle after the strobe, so sample at the following falling edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(negedge mclk);
		check(rdata, exp, what);
	endtask : rd

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_values();
		rd(8'h00, 8'h00, "bank select reset");
		rd(8'h04, 8'h85, "protection reset");
		rd(8'h05, 8'h00, "master config reset");
		rd(8'h01, TB_ID[7:0], "id low");
		rd(8'h02, TB_ID[15:8], "id high");
		rd(8'h03, TB_REV, "revision");
		check({4'h0, strap_value}, 8'h0A, "strap capture");
		$display("test reset_values done");
	endtask : t_reset_values
	task automatic t_read_only();
		wr(8'h01, 8'hFF);
		wr(8'h02, 8'hFF);
		wr(8'h03, 8'hFF);
		wr(8'h20, 8'h55);
		rd(8'h01, TB_ID[7:0], "id low kept");
		rd(8'h02, TB_ID[15:8], "id high kept");
		rd(8'h03, TB_REV, "revision kept");
		rd(8'h20, 8'h00, "unmapped read");
		$display("test read_only done");
	endtask : t_read_only
	task automatic t_protected();
		wr(8'h04, 8'h12);
		rd(8'h04, 8'h12, "protection write taken");
		check({6'h0, protect_mode}, 8'h00, "protected mode");
		wr(8'h05, 8'h0F);
		wr(8'h00, 8'h01);
		rd(8'h05, 8'h00, "config write dropped");
		rd(8'h00, 8'h00, "bank select write dropped");
		$display("test protected done");
	endtask : t_protected
	task automatic t_single();
		wr(8'h04, 8'h86);
		check({6'h0, protect_mode}, 8'h01, "single mode");
		wr(8'h05, 8'h0A);
		check(banks, 8'h0A, "bank selects a and c");
		rd(8'h04, 8'h00, "relocked");
		wr(8'h05, 8'h05);
		rd(8'h05, 8'h0A, "second write dropped");
		$display("test single done");
	endtask : t_single
	task automatic t_full();
		wr(8'h04, 8'h85);
		check({6'h0, protect_mode}, 8'h02, "full mode");
		wr(8'h05, 8'h05);
		check(banks, 8'h05, "bank selects b and d");
		wr(8'h05, 8'h03);
		rd(8'h05, 8'h03, "repeated write");
		rd(8'h04, 8'h85, "code kept");
		$display("test full done");
	endtask : t_full
	task automatic t_bank_select();
		wr(8'h00, 8'h01);
		@(posedge mclk);
		addr  <= 8'h05;
		wdata <= 8'h3C;
		wr_en <= 1'b1;
		@(negedge mclk);
		check({mem_wr, memory_bank_select, mem_addr[5:0]}, 8'hC5, "memory write");
		check(mem_wdata, 8'h3C, "memory data");
		@(posedge mclk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(negedge mclk);
		check({6'h00, mem_rd, mem_wr}, 8'h02, "memory read strobe");
		@(posedge mclk);
		rd_en <= 1'b0;
		@(negedge mclk);
		check(rdata, 8'hC3, "memory read");
		rd(8'h00, 8'h01, "address zero kept");
		wr(8'h00, 8'h00);
		rd(8'h05, 8'h03, "registers back");
		$display("test bank_select done");
	endtask : t_bank_select
	task automatic t_soft_reset();
		wr(8'h05, 8'h0F);
		wr(8'h04, 8'h86);
		@(posedge mclk);
		strap_pins <= 4'h5;
		wr(8'h05, 8'h8F);
		check({7'h0, soft_reset}, 8'h01, "soft reset set");
		wr(8'h00, 8'h01);
		rd(8'h00, 8'h00, "bank select default");
		rd(8'h04, 8'h85, "protection default");
		rd(8'h05, 8'h80, "config default");
		check(banks, 8'h00, "bank selects default");
		check({4'h0, strap_value}, 8'h0A, "straps not resampled");
		wr(8'h05, 8'h00);
		check({7'h0, soft_reset}, 8'h00, "soft reset cleared");
		check({4'h0, strap_value}, 8'h0A, "straps still latched");
		$display("test soft_reset done");
	endtask : t_soft_reset

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			summarize();
		end
	end
	initial begin
		nrst = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		strap_pins = 4'hA;
		mem_rdata = 8'hC3;
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		t_reset_values();
		t_read_only();
		t_protected();
		t_single();
		t_full();
		t_bank_select();
		t_soft_reset();
		summarize();
	end
endmodule : tb_gcr_global_regs
`default_nettype wire
